// File: logic/cgo_top.sv
// Clock generator output control: AXI4-Lite registers, fuse load, output enables
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module cgo_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Control pins
   input wire logic clock_out_a_enable_pin,
   input wire logic clock_out_b_enable_pin,
   input wire logic bypass_out_enable_pin,
   input wire logic pll_power_down_n,
   input wire logic chip_select_fuse_pin,
   input wire logic pll_locked,
   // Fuse array
   output logic [2:0] fuse_rd_addr,
   input wire logic [31:0] fuse_rd_data,
   output logic fuse_prog_en,
   output logic [2:0] fuse_prog_addr,
   output logic [31:0] fuse_prog_data,
   // Output buffer controls, index 0 = a, 1 = b, 2 = bypass
   output logic [2:0] out_pos_oe,
   output logic [2:0] out_neg_oe,
   output logic [2:0] out_switch_en,
   // Analog configuration
   output logic pll_power_down,
   output logic [8:0] cfg_format,
   output logic [1:0] cfg_pll_mode,
   output logic [10:0] cfg_fb_int,
   output logic [27:0] cfg_fb_frac,
   output logic [15:0] cfg_ratio_num,
   output logic [15:0] cfg_ratio_den,
   output logic [25:0] cfg_out_div,
   // Status
   output logic lock_lost,
   output logic irq
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam logic [8:0] SETTLE_LAST = 9'(cgo_pkg::SETTLE_CYC - 1);
   cgo_pkg::cgo_state_t state;
   logic [3:0] load_idx;
   logic load_wr;
   logic [2:0] en_bit;
   logic [2:0] ovr_bit;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_got;
   logic w_got;
   logic next_aw_got;
   logic next_w_got;
   logic do_wr;
   logic wr_go;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [31:0] wr_mask;
   logic wr_mapped;
   logic rd_take;
   logic [31:0] rd_word;
   logic rd_mapped;
   logic [2:0] pin_in;
   logic [2:0] want_on;
   logic [1:0] irq_ev;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic lock_prev;
   logic [31:0] ctrl_view;

   // ------------------------------------------------------------
   // Fuse load sequence
   // ------------------------------------------------------------
   // Reads one fuse word per cycle; data is taken in the same cycle as the address
   // load factory fuses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= cgo_pkg::CGO_LOAD;
         load_idx <= 4'h0;
         load_wr <= 1'b0;
      end
      else
      begin
         case (state)
            cgo_pkg::CGO_LOAD:
            begin
               load_wr <= (load_idx < 4'(cgo_pkg::FUSE_WORDS));
               if (load_idx < 4'(cgo_pkg::FUSE_WORDS))
                  load_idx <= load_idx + 4'h1;
               else
                  state <= cgo_pkg::CGO_RUN;
            end
            cgo_pkg::CGO_RUN: load_wr <= 1'b0;
            default: state <= cgo_pkg::CGO_LOAD;
         endcase
      end
   end

   // Fuse read address follows the load index
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fuse_rd_addr <= 3'h0;
      else
         fuse_rd_addr <= load_idx[2:0];
   end

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   assign do_wr = aw_got && w_got && !s_axi_bvalid;
   assign next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready)) && !do_wr;
   assign next_w_got = (w_got || (s_axi_wvalid && s_axi_wready)) && !do_wr;

   // Address and data are taken independently, in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         if (s_axi_awvalid && s_axi_awready)
            aw_addr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Refused while fuses load so software cannot race the defaults
         s_axi_awready <= (state == cgo_pkg::CGO_RUN) && !next_aw_got;
         s_axi_wready <= (state == cgo_pkg::CGO_RUN) && !next_w_got;
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (do_wr)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Shared write port: fuse load or bus write
   always_comb
   begin
      wr_go = load_wr || do_wr;
      wr_addr = load_wr ? {3'h0, fuse_rd_addr, 2'h0} : aw_addr;
      wr_data = load_wr ? fuse_rd_data : w_data;
      wr_mask = load_wr ? 32'hFFFF_FFFF : {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
      wr_mapped = (aw_addr <= cgo_pkg::ADDR_IRQ_MASK) && (aw_addr[1:0] == 2'h0);
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // format, bypass source and divisor fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en_bit <= 3'(cgo_pkg::RST_ZERO);
         ovr_bit <= 3'(cgo_pkg::RST_ZERO);
         cfg_format <= 9'(cgo_pkg::RST_ZERO);
         cfg_pll_mode <= cgo_pkg::MODE_INT;
         cfg_fb_int <= 11'(cgo_pkg::RST_ZERO);
         cfg_fb_frac <= 28'(cgo_pkg::RST_ZERO);
         cfg_ratio_num <= 16'(cgo_pkg::RST_ZERO);
         cfg_ratio_den <= 16'(cgo_pkg::RST_ZERO);
         cfg_out_div <= 26'(cgo_pkg::RST_DIV);
         irq_mask <= 2'(cgo_pkg::RST_ZERO);
      end
      else if (wr_go)
      begin
         case (wr_addr)
            cgo_pkg::ADDR_OUT_CTRL:
            begin
               en_bit <= (en_bit & ~wr_mask[2:0]) | (wr_data[2:0] & wr_mask[2:0]);
               ovr_bit <= (ovr_bit & ~wr_mask[6:4]) | (wr_data[6:4] & wr_mask[6:4]);
            end
            cgo_pkg::ADDR_FORMAT:
               cfg_format <= (cfg_format & ~wr_mask[8:0]) | (wr_data[8:0] & wr_mask[8:0]);
            cgo_pkg::ADDR_PLL_MODE:
               // Code 3 is not a mode and is not stored
               if (wr_mask[0] && wr_data[1:0] != 2'h3)
                  cfg_pll_mode <= wr_data[1:0];
            cgo_pkg::ADDR_FB_INT:
               cfg_fb_int <= (cfg_fb_int & ~wr_mask[10:0]) | (wr_data[10:0] & wr_mask[10:0]);
            cgo_pkg::ADDR_FB_FRAC:
               cfg_fb_frac <= (cfg_fb_frac & ~wr_mask[27:0]) | (wr_data[27:0] & wr_mask[27:0]);
            cgo_pkg::ADDR_RATIO_NUM:
               cfg_ratio_num <= (cfg_ratio_num & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
            cgo_pkg::ADDR_RATIO_DEN:
               cfg_ratio_den <= (cfg_ratio_den & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
            cgo_pkg::ADDR_OUT_DIV:
            begin
               if (wr_mask[0])
                  cfg_out_div[9:0] <= {wr_data[cgo_pkg::HALF_POS], div_clamp(wr_data[8:0])};
               if (wr_mask[2])
                  cfg_out_div[25:16] <= {wr_data[cgo_pkg::DIV_B_POS + cgo_pkg::HALF_POS],
                                         div_clamp(wr_data[24:16])};
            end
            cgo_pkg::ADDR_IRQ_MASK:
               if (wr_mask[0])
                  irq_mask <= wr_data[1:0];
            default: ;
         endcase
      end
   end

   // Keeps an output divider inside its legal span
   function automatic logic [8:0] div_clamp(input logic [8:0] v);
      if (v < cgo_pkg::DIV_MIN)
         div_clamp = cgo_pkg::DIV_MIN;
      else if (v > cgo_pkg::DIV_MAX)
         div_clamp = cgo_pkg::DIV_MAX;
      else
         div_clamp = v;
   endfunction : div_clamp

   // Bits 15:10 of the divider word are never written and stay zero
   logic unused_div;
   assign unused_div = ^cfg_out_div[15:10];

   // ------------------------------------------------------------
   // Fuse programming
   // ------------------------------------------------------------
   // high chip-select programs fuses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fuse_prog_en <= 1'b0;
         fuse_prog_addr <= 3'h0;
         fuse_prog_data <= 32'h0000_0000;
      end
      else
      begin
         fuse_prog_en <= do_wr && chip_select_fuse_pin && (aw_addr < cgo_pkg::ADDR_STATUS) && (aw_addr[1:0] == 2'h0);
         if (do_wr)
         begin
            fuse_prog_addr <= aw_addr[4:2];
            fuse_prog_data <= w_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Output enables and settle hold
   // ------------------------------------------------------------
   assign pin_in = {bypass_out_enable_pin, clock_out_b_enable_pin, clock_out_a_enable_pin};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pll_power_down <= 1'b1;
      else
         pll_power_down <= !pll_power_down_n;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_out
         logic [8:0] settle_cnt;
         logic [1:0] fmt;
         assign fmt = cfg_format[cgo_pkg::FMT_POS + 2 * gi +: 2];
         if (gi < 2)
         begin : g_pll
            assign want_on[gi] = en_bit[gi] && (ovr_bit[gi] || pin_in[gi]) && pll_power_down_n
                                 && (state == cgo_pkg::CGO_RUN);
         end
         else
         begin : g_byp
            assign want_on[gi] = en_bit[gi] && (ovr_bit[gi] || pin_in[gi]) && (state == cgo_pkg::CGO_RUN);
         end

         // pin drivers by enable and format
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               out_pos_oe[gi] <= 1'b0;
               out_neg_oe[gi] <= 1'b0;
            end
            else
            begin
               out_pos_oe[gi] <= want_on[gi];
               out_neg_oe[gi] <= want_on[gi] && (fmt != cgo_pkg::FMT_CMOS);
            end
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               settle_cnt <= 9'h000;
               out_switch_en[gi] <= 1'b0;
            end
            else if (!want_on[gi])
            begin
               settle_cnt <= 9'h000;
               out_switch_en[gi] <= 1'b0;
            end
            else if (settle_cnt < SETTLE_LAST)
               settle_cnt <= settle_cnt + 9'h001;
            else
               out_switch_en[gi] <= 1'b1;
         end

         AST_SETTLE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(out_pos_oe[gi]) |-> !out_switch_en[gi] [*8])
            else $error("output switched before the settle hold");
         // disabled output leaves both pins undriven
         AST_OFF_TRISTATE: assert property (@(posedge aclk) disable iff (!aresetn)
            !want_on[gi] |=> !out_pos_oe[gi] && !out_neg_oe[gi])
            else $error("disabled output still drives a pin");
      end
   endgenerate

   // ------------------------------------------------------------
   // Lock status and interrupts
   // ------------------------------------------------------------
   // loss of lock while powered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lock_lost <= 1'b0;
         lock_prev <= 1'b0;
      end
      else
      begin
         lock_lost <= pll_power_down_n && !pll_locked;
         lock_prev <= lock_lost;
      end
   end

   // Bit 0 lock lost, bit 1 lock regained
   assign irq_ev = {lock_prev && !lock_lost, !lock_prev && lock_lost};

   // Read of the status clears it; a same-cycle event survives the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= 2'h0;
      else if (rd_take && s_axi_araddr == cgo_pkg::ADDR_IRQ_STATUS)
         irq_status <= irq_ev;
      else
         irq_status <= irq_status | irq_ev;
   end

   // Level interrupt from unmasked sticky bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(next_irq_status() & irq_mask);
   end

   // Status value that the sticky register takes at this edge
   function automatic logic [1:0] next_irq_status();
      if (rd_take && s_axi_araddr == cgo_pkg::ADDR_IRQ_STATUS)
         next_irq_status = irq_ev;
      else
         next_irq_status = irq_status | irq_ev;
   endfunction : next_irq_status

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign ctrl_view = {17'h0, out_pos_oe, 1'b0, pin_in & ~ovr_bit, 1'b0, ovr_bit, 1'b0, en_bit};

   always_comb
   begin
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         cgo_pkg::ADDR_OUT_CTRL: rd_word = ctrl_view;
         cgo_pkg::ADDR_FORMAT: rd_word = {23'h0, cfg_format};
         cgo_pkg::ADDR_PLL_MODE: rd_word = {30'h0, cfg_pll_mode};
         cgo_pkg::ADDR_FB_INT: rd_word = {21'h0, cfg_fb_int};
         cgo_pkg::ADDR_FB_FRAC: rd_word = {4'h0, cfg_fb_frac};
         cgo_pkg::ADDR_RATIO_NUM: rd_word = {16'h0, cfg_ratio_num};
         cgo_pkg::ADDR_RATIO_DEN: rd_word = {16'h0, cfg_ratio_den};
         cgo_pkg::ADDR_OUT_DIV: rd_word = {6'h0, cfg_out_div};
         cgo_pkg::ADDR_STATUS: rd_word = {29'h0, pll_power_down, chip_select_fuse_pin, lock_lost};
         cgo_pkg::ADDR_IRQ_STATUS: rd_word = {30'h0, irq_status};
         cgo_pkg::ADDR_IRQ_MASK: rd_word = {30'h0, irq_mask};
         default:
         begin
            rd_word = 32'h0000_0000;
            rd_mapped = 1'b0;
         end
      endcase
   end

   // One read in flight; data registered on the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         if (rd_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? 2'h0 : 2'h2;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
         s_axi_arready <= !rd_take && !(s_axi_rvalid && !s_axi_rready);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_pd_held;
      !pll_power_down_n [*2];
   endsequence
   AST_PD_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pd_held |-> out_pos_oe[1:0] == 2'h0 && pll_power_down)
      else $error("PLL output driven during power-down");
   AST_CMOS_NEG: assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg_format[3:2] == cgo_pkg::FMT_CMOS && $stable(cfg_format)) |=> !out_neg_oe[0])
      else $error("negative pin driven in CMOS format");
   AST_BYP_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !bypass_out_enable_pin && !ovr_bit[2] |=> !out_pos_oe[2] && !out_neg_oe[2])
      else $error("bypass output driven with its enable low");
   AST_OVR_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == cgo_pkg::CGO_RUN && ovr_bit[2] && en_bit[2] && $stable(en_bit)) |=> out_pos_oe[2])
      else $error("override did not enable the output");
   AST_AND_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
      out_pos_oe[2] |-> $past(en_bit[2]) && ($past(pin_in[2]) || $past(ovr_bit[2])))
      else $error("output enabled without pin and register bit");
   AST_FUSE_PROG: assert property (@(posedge aclk) disable iff (!aresetn)
      fuse_prog_en |-> $past(chip_select_fuse_pin) && $past(do_wr))
      else $error("fuse programmed without the chip-select level");
   AST_LOAD_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> ##[1:12] state == cgo_pkg::CGO_RUN)
      else $error("fuse load did not finish");
   // Status bit follows the flag by one cycle; a later read may clear it while still unlocked
   sequence s_lock_report;
      lock_lost ##1 irq_status[0];
   endsequence
   AST_LOCK_LOST: assert property (@(posedge aclk) disable iff (!aresetn)
      (pll_power_down_n && !pll_locked && !lock_lost) |=> s_lock_report)
      else $error("loss of lock not reported");
   AST_DIV_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_out_div[8:0] >= cgo_pkg::DIV_MIN && cfg_out_div[24:16] <= cgo_pkg::DIV_MAX)
      else $error("output divider out of range");
endmodule : cgo_top

// File: logic/cgo_pkg.sv
// Constants, register map and types of the clock generator output control block
// What this block does
// - PLL output enable low tristates both pins
// - Bypass enable low tristates both bypass pins
// - Power-down input disables and tristates PLL outputs
// - CMOS format drives positive pin only
// - High chip-select level turns writes into fuse programming
// - Reference input format: CMOS, LVDS, LVPECL, HCSL
// - Output formats: CMOS, LVDS, LVPECL codes
// - Outputs gated by pin and register bit
// - Integer, fractional, ratio modes; eighths in integer
// - Fractional divisor: 11-bit integer, 28-bit fraction
// - Ratio divisor N plus X over Y
// - Output dividers 4 to 259, plus 4.5
// - Load factory fuses at power-up, then writable
// - Report PLL loss of lock
// - Bypass output sources crystal or external reference
// - Default enable is pin AND register bit
// - Override ignores pin; override and bit enable
// - Hold static about 2 us before switching
package cgo_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_OUT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FORMAT = 8'h04;
   localparam logic [7:0] ADDR_PLL_MODE = 8'h08;
   localparam logic [7:0] ADDR_FB_INT = 8'h0C;
   localparam logic [7:0] ADDR_FB_FRAC = 8'h10;
   localparam logic [7:0] ADDR_RATIO_NUM = 8'h14;
   localparam logic [7:0] ADDR_RATIO_DEN = 8'h18;
   localparam logic [7:0] ADDR_OUT_DIV = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OVR_POS = 4;        // OUT_CTRL override bits [6:4]
   localparam int PIN_POS = 8;        // OUT_CTRL pin view [10:8]
   localparam int ACT_POS = 12;       // OUT_CTRL active view [14:12]
   localparam int FMT_POS = 2;        // FORMAT output fields at [3:2],[5:4],[7:6]
   localparam int BYP_SRC_POS = 8;    // FORMAT bypass source select
   localparam int DIV_B_POS = 16;     // OUT_DIV divider b field
   localparam int HALF_POS = 9;       // Divide-by-4.5 flag inside a divider field
   // ------------------------------------------------------------
   // Encodings, limits, reset values
   // ------------------------------------------------------------
   localparam logic [1:0] FMT_CMOS = 2'h0;
   localparam logic [1:0] FMT_LVDS = 2'h1;
   localparam logic [1:0] FMT_LVPECL = 2'h2;
   localparam logic [1:0] FMT_HCSL = 2'h3;    // Reference input only
   localparam logic [1:0] MODE_INT = 2'h0;
   localparam logic [1:0] MODE_FRAC = 2'h1;
   localparam logic [1:0] MODE_RATIO = 2'h2;
   localparam logic [8:0] DIV_MIN = 9'h004;
   localparam logic [8:0] DIV_MAX = 9'h103;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_DIV = 32'h0004_0004;
   localparam int FUSE_WORDS = 8;     // Fuse word i loads register at byte 4*i
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic {CGO_LOAD, CGO_RUN} cgo_state_t;
endpackage : cgo_pkg

// File: tb/cgo_fuse_model.sv
// Factory fuse array model that feeds the power-up load
`timescale 1ns/1ns
module cgo_fuse_model (
   // Read port
   input wire logic [2:0] fuse_rd_addr,
   output logic [31:0] fuse_rd_data
);
   // factory words
   // Word 0 enables all outputs; other words carry their own index
   always_comb
   begin
      fuse_rd_data = (fuse_rd_addr == 3'h0) ? 32'h7 : 32'(fuse_rd_addr);
   end
endmodule : cgo_fuse_model

// File: tb/testbench.sv
// Self-checking bench for the clock generator output control block
`timescale 1ns/1ns
module testbench;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, fuse_prog_en, pll_power_down, lock_lost, irq, prog_seen = 0;
   logic clock_out_a_enable_pin = 1, clock_out_b_enable_pin = 1, bypass_out_enable_pin = 1;
   logic pll_power_down_n = 1, chip_select_fuse_pin = 0, pll_locked = 1;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, fuse_rd_data, fuse_prog_data, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, cfg_pll_mode, resp;
   logic [2:0] fuse_rd_addr, fuse_prog_addr, out_pos_oe, out_neg_oe, out_switch_en;
   logic [8:0] cfg_format;
   logic [10:0] cfg_fb_int;
   logic [27:0] cfg_fb_frac;
   logic [15:0] cfg_ratio_num, cfg_ratio_den;
   logic [25:0] cfg_out_div;
   int errors = 0, comparisons = 0;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cgo_row_t;
   // Register rows: address, written word, word read back
   cgo_row_t rows [15] = '{'{8'h04, 32'h3, 32'h3}, '{8'h04, 32'h19, 32'h19}, '{8'h04, 32'h162, 32'h162},
      '{8'h04, 32'h10, 32'h10}, '{8'h08, 32'h1, 32'h1}, '{8'h08, 32'h2, 32'h2}, '{8'h08, 32'h3, 32'h2},
      '{8'h08, 32'h0, 32'h0}, '{8'h0C, 32'h7FF, 32'h7FF}, '{8'h10, 32'hFFFFFFFF, 32'hFFFFFFF},
      '{8'h14, 32'hABCD, 32'hABCD}, '{8'h18, 32'h1234, 32'h1234}, '{8'h1C, 32'h1030103, 32'h1030103},
      '{8'h1C, 32'h2040204, 32'h2040204}, '{8'h1C, 32'h2, 32'h40004}};
   cgo_top cgo_top_inst (.*);
   cgo_fuse_model cgo_fuse_model_inst (.*);
   // 125 MHz clock
   always #4 aclk = ~aclk;
   // Catch the one-cycle fuse write pulse
   always @(posedge aclk)
      if (fuse_prog_en) prog_seen <= 1'b1;
   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : check
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 400; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      errors += (n == 400);
      if (n == 400) tally_and_finish();
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 400; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      errors += (n == 400);
      if (n == 400) tally_and_finish();
      @(posedge aclk);
   endtask : axi_rd
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge aclk);
      check("pd_rst", 32'h1, 32'(pll_power_down));
      check("div_rst", 32'h40004, 32'(cfg_out_div));
      aresetn <= 1'b1;
      repeat (12) @(posedge aclk);
      axi_rd(8'h00);
      check("fuse_en", 32'h7, rd & 32'h7);
      axi_rd(8'h08);
      check("fuse_mode", 32'h2, rd);
      foreach (rows[i])
      begin
         axi_wr(rows[i].a, rows[i].d);
         axi_rd(rows[i].a);
         check("row", rows[i].e, rd);
      end
      // Configuration ports must carry what the rows left behind
      check("cfg_fmt", 32'h10, 32'(cfg_format));
      check("cfg_mode", 32'h0, 32'(cfg_pll_mode));
      check("cfg_int", 32'h7FF, 32'(cfg_fb_int));
      check("cfg_frac", 32'hFFFFFFF, 32'(cfg_fb_frac));
      check("cfg_ratio", 32'hABCD1234, {cfg_ratio_num, cfg_ratio_den});
      check("cfg_div", 32'h40004, 32'(cfg_out_div));
      check("pos_oe", 32'h7, 32'(out_pos_oe));
      check("neg_oe", 32'h2, 32'(out_neg_oe));
      // Pins low: a and bypass must release their positive pins
      clock_out_a_enable_pin <= 1'b0;
      bypass_out_enable_pin <= 1'b0;
      repeat (2) @(posedge aclk);
      check("pin_off", 32'h2, 32'(out_pos_oe));
      axi_wr(8'h00, 32'h17);
      check("ovr_on", 32'h3, 32'(out_pos_oe));
      check("sw_early", 32'h0, 32'(out_switch_en[0]));
      repeat (252) @(posedge aclk);
      check("sw_late", 32'h3, 32'(out_switch_en[1:0]));
      pll_power_down_n <= 1'b0;
      repeat (2) @(posedge aclk);
      // All positive pins released, marker bit, PLL powered down
      check("pd_oe", 32'h3, {out_pos_oe, 1'b1, pll_power_down});
      pll_power_down_n <= 1'b1;
      axi_wr(8'h28, 32'h1);
      axi_rd(8'h24);
      pll_locked <= 1'b0;
      repeat (4) @(posedge aclk);
      check("irq_set", 32'h3, 32'({lock_lost, irq}));
      pll_locked <= 1'b1;
      repeat (4) @(posedge aclk);
      axi_rd(8'h24);
      // Both status bits read back, interrupt dropped by the clearing read
      check("irq_stat", 32'h6, {rd[30:0], irq});
      axi_wr(8'h40, 32'h1);
      check("bresp", 32'h2, 32'(resp));
      axi_rd(8'h40);
      check("rresp", 32'h2, 32'(resp));
      chip_select_fuse_pin <= 1'b1;
      axi_wr(8'h08, 32'h1);
      check("prog", 32'hA, 32'({prog_seen, fuse_prog_addr}));
      check("prog_data", 32'h1, fuse_prog_data);
      tally_and_finish();
   end
endmodule : testbench
